// ==== verilog/ssps_top.sv ====
// serial port in spi role with avalon-mm register access
`timescale 1ns/100ps

// Functional notes
// - eight bits shift out and in together
// - master sample point: middle or end of bit
// - phase and idle level pick output edge
// - data/address flag shows last byte kind
// - stop flag: stop latest, cleared otherwise
// - start flag: start latest, cleared otherwise
// - read/write flag holds last address direction
// - address refresh flag for ten-bit addressing
// - buffer full set on received word
// - write during shift sets sticky collision
// - slave overrun sets overflow, drops word
// - overflow set by hardware only in spi slave modes, never in i2c; software clears
// - enable hands pins to the port
// - idle level of serial clock in spi
// - i2c clock held low when idle bit clear
// - spi master and slave mode codes
// - i2c mode codes, others reserved
// - chip select high resets slave transfer
module ssps_top
(
  input  wire logic                    clock,
  input  wire logic                    srst,
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    timer_two_output,
  input  wire logic                    sck_i,
  input  wire logic                    serial_in,
  input  wire logic                    cs_n,
  output ssps_pkg::ssps_pins_out_t     pins,
  output logic                         port_irq
);

  // pin synchronisers, first stage read only by second
  logic [2:0] meta_ff;                 // sck, sdi, cs_n first stage
  logic [2:0] sync_ff;                 // second stage
  logic       sck_prev_ff;             // for slave clock edges
  logic       tmr_meta_ff;             // timer first stage
  logic       tmr_sync_ff;             // timer second stage
  logic       tmr_prev_ff;             // timer edge detect

  // registers
  logic [7:0] status_ff;               // sample, phase and i2c flags
  logic [7:0] control_ff;              // collision, overflow, enable, idle, mode
  logic [7:0] buffer_ff;               // transfer_buffer
  logic [7:0] shift_reg_ff;            // shift_reg
  logic [7:0] tx_hold_ff;              // word written for transmit
  logic       buffer_full_ff;          // buffer_full
  logic       irq_ff;                  // port interrupt flag
  logic       busy_ff;                 // transfer in progress
  logic [3:0] edge_cnt_ff;             // clock edges done (16 per word)
  logic [5:0] div_cnt_ff;              // master divider
  logic       sck_ff;                  // master clock level
  logic       sdo_ff;                  // serial_out level
  logic       mid_sample_ff;           // bit sampled at mid point
  logic       ack_ff;                  // bus answer pending

  // decoded control
  ssps_pkg::ssps_mode_t mode;
  logic port_enable;
  logic clock_idle_level;
  logic input_sample_point;
  logic phase;
  logic is_master;
  logic is_slave;
  logic is_i2c;
  assign mode               = ssps_pkg::ssps_mode_t'(control_ff[3:0]);
  assign port_enable        = control_ff[ssps_pkg::CT_EN];
  assign clock_idle_level   = control_ff[ssps_pkg::CT_IDLE];
  assign input_sample_point = status_ff[ssps_pkg::ST_SAMPLE];
  assign phase              = status_ff[ssps_pkg::ST_CKE];
  // phase 0 moves data on the edge back to idle, phase 1 on the edge leaving it
  logic shift_trail;
  assign shift_trail = ~phase;

  // mode decode
  always_comb
  begin
    is_master = 1'b0;
    is_slave  = 1'b0;
    is_i2c    = 1'b0;
    case (mode)
      ssps_pkg::SSPS_M_DIV4, ssps_pkg::SSPS_M_DIV16,
      ssps_pkg::SSPS_M_DIV64, ssps_pkg::SSPS_M_TMR:
        is_master = 1'b1;
      ssps_pkg::SSPS_S_CS, ssps_pkg::SSPS_S_NOCS:
        is_slave = 1'b1;
      ssps_pkg::SSPS_I2C7, ssps_pkg::SSPS_I2C10,
      ssps_pkg::SSPS_I2C7_SP, ssps_pkg::SSPS_I2C10_SP:
        is_i2c = 1'b1;
      default:                         // reserved codes: port idle
        is_master = 1'b0;
    endcase
  end

  // divider half period select
  function automatic logic [5:0] half_period(input logic [3:0] m);
    case (m)
      4'h1:    half_period = ssps_pkg::HALF_DIV16;
      4'h2:    half_period = ssps_pkg::HALF_DIV64;
      default: half_period = ssps_pkg::HALF_DIV4;
    endcase
  endfunction

  // bus decode
  logic bus_wr;
  logic bus_rd;
  logic wr_status;
  logic wr_control;
  logic wr_buffer;
  logic wr_events;
  logic rd_buffer;
  assign bus_wr     = avs_write & ~ack_ff & avs_byteenable[0];
  assign bus_rd     = avs_read & ~ack_ff;
  assign wr_status  = bus_wr & (avs_address == ssps_pkg::ADDR_STATUS);
  assign wr_control = bus_wr & (avs_address == ssps_pkg::ADDR_CONTROL);
  assign wr_buffer  = bus_wr & (avs_address == ssps_pkg::ADDR_BUFFER);
  assign wr_events  = bus_wr & (avs_address == ssps_pkg::ADDR_EVENTS);
  assign rd_buffer  = bus_rd & (avs_address == ssps_pkg::ADDR_BUFFER);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

  // one wait state: request accepted, answer next edge
  always_ff @(posedge clock)
  begin
    if (srst)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
  end

  // read data capture, unmapped reads zero
  always_ff @(posedge clock)
  begin
    if (srst)
      avs_readdata <= 32'h0;
    else if (bus_rd)
    begin
      case (avs_address)
        ssps_pkg::ADDR_STATUS:  avs_readdata <= {24'h0, status_ff[7:1], buffer_full_ff};
        ssps_pkg::ADDR_CONTROL: avs_readdata <= {24'h0, control_ff};
        ssps_pkg::ADDR_BUFFER:  avs_readdata <= {24'h0, buffer_ff};
        ssps_pkg::ADDR_EVENTS:  avs_readdata <= {31'h0, irq_ff};
        default:                avs_readdata <= 32'h0;
      endcase
    end
  end

  // two-flop synchronisers for pins
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      meta_ff     <= 3'h4;
      sync_ff     <= 3'h4;
      sck_prev_ff <= 1'b0;
      tmr_meta_ff <= 1'b0;
      tmr_sync_ff <= 1'b0;
      tmr_prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff     <= {cs_n, serial_in, sck_i};
      sync_ff     <= meta_ff;
      sck_prev_ff <= sync_ff[0];
      tmr_meta_ff <= timer_two_output;
      tmr_sync_ff <= tmr_meta_ff;
      tmr_prev_ff <= tmr_sync_ff;
    end
  end

  logic sck_s;
  logic sdi_s;
  logic cs_high;
  assign sck_s   = sync_ff[0];
  assign sdi_s   = sync_ff[1];
  assign cs_high = sync_ff[2];

  // chip select reset of slave logic
  logic xfer_reset;
  assign xfer_reset = ~port_enable | ~(is_master | is_slave)
                    | (mode == ssps_pkg::SSPS_S_CS & cs_high);

  // master tick generation: one tick per half clock period
  logic m_tick;
  assign m_tick = (mode == ssps_pkg::SSPS_M_TMR) ? (tmr_sync_ff & ~tmr_prev_ff)
                : (div_cnt_ff == 6'h01);

  always_ff @(posedge clock)
  begin
    if (srst | ~busy_ff)
      div_cnt_ff <= half_period(control_ff[3:0]);
    else if (div_cnt_ff == 6'h01)
      div_cnt_ff <= half_period(control_ff[3:0]);
    else
      div_cnt_ff <= div_cnt_ff - 6'h01;
  end

  // clock edge events. leading edge leaves idle, trailing returns to it
  logic lead_edge;
  logic trail_edge;
  always_comb
  begin
    lead_edge  = 1'b0;
    trail_edge = 1'b0;
    if (is_master & busy_ff & m_tick)
    begin
      lead_edge  = ~edge_cnt_ff[0];
      trail_edge = edge_cnt_ff[0];
    end
    else if (is_slave & ~xfer_reset & (sck_s != sck_prev_ff))
    begin
      lead_edge  = (sck_s != clock_idle_level);
      trail_edge = (sck_s == clock_idle_level);
    end
  end

  // data changes on trailing edge for phase 0, leading for phase 1
  logic shift_edge;
  logic sample_edge;
  assign shift_edge  = shift_trail ? trail_edge : lead_edge;
  assign sample_edge = shift_trail ? lead_edge : trail_edge;

  // sample point: middle edge, or end of bit in master with sample bit set
  // input path adds two clocks: at the /4 rate middle sampling sees the old bit
  logic do_sample;
  logic end_sample;
  assign end_sample = is_master & input_sample_point;
  assign do_sample  = end_sample ? shift_edge : sample_edge;

  // word complete at sixteenth edge
  logic word_done;
  assign word_done = (lead_edge | trail_edge) & (edge_cnt_ff == 4'hf);

  // transfer engine: msb first shift, edge counter
  always_ff @(posedge clock)
  begin
    if (srst | xfer_reset)
    begin
      busy_ff       <= 1'b0;
      edge_cnt_ff   <= 4'h0;
      shift_reg_ff  <= 8'h00;
      mid_sample_ff <= 1'b0;
    end
    else
    begin
      if (wr_buffer & ~busy_ff)                  // write starts a word
      begin
        busy_ff      <= 1'b1;
        shift_reg_ff <= avs_writedata[7:0];
      end
      else if (is_slave & ~busy_ff & (lead_edge | trail_edge))
        busy_ff <= 1'b1;                         // slave word begun by clock
      if (lead_edge | trail_edge)
        edge_cnt_ff <= edge_cnt_ff + 4'h1;
      if (do_sample)
        mid_sample_ff <= sdi_s;                  // capture in step with clock
      if (shift_edge & (edge_cnt_ff != 4'h0 | ~shift_trail))
        shift_reg_ff <= {shift_reg_ff[6:0], (end_sample ? sdi_s : mid_sample_ff)};  // end sampling takes line now
      if (word_done)
        busy_ff <= 1'b0;
    end
  end

  // final bit folded into the completed word
  logic [7:0] rx_word;
  assign rx_word = end_sample ? {shift_reg_ff[6:0], sdi_s}
                 : {shift_reg_ff[6:0], (do_sample ? sdi_s : mid_sample_ff)};

  // transmit line: msb of shift register or held word
  always_ff @(posedge clock)
  begin
    if (srst)
      sdo_ff <= 1'b0;
    else if (wr_buffer & ~busy_ff)
      sdo_ff <= avs_writedata[7];
    else if (shift_edge & ~word_done)
      sdo_ff <= (edge_cnt_ff == 4'h0 & ~shift_trail) ? shift_reg_ff[7] : shift_reg_ff[6];
  end

  // held copy for slaves that answer without a write
  always_ff @(posedge clock)
  begin
    if (srst)
      tx_hold_ff <= 8'h00;
    else if (wr_buffer)
      tx_hold_ff <= avs_writedata[7:0];
  end

  // master clock level, idle per idle bit
  always_ff @(posedge clock)
  begin
    if (srst | ~busy_ff)
      sck_ff <= clock_idle_level;
    else if (is_master & m_tick)
      sck_ff <= ~sck_ff;
  end

  // buffer, full flag and overflow
  logic overflow_now;
  assign overflow_now = word_done & buffer_full_ff & is_slave;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      buffer_ff      <= 8'h00;
      buffer_full_ff <= 1'b0;
    end
    else if (word_done & ~overflow_now)
    begin
      buffer_ff      <= rx_word;
      buffer_full_ff <= 1'b1;
    end
    else if (rd_buffer)
      buffer_full_ff <= 1'b0;
  end

  // control register with sticky hardware flags; set wins over clear
  always_ff @(posedge clock)
  begin
    if (srst)
      control_ff <= ssps_pkg::RST_CONTROL;
    else
    begin
      if (wr_control)
        control_ff <= avs_writedata[7:0];
      if (wr_buffer & busy_ff)
        control_ff[ssps_pkg::CT_COLL] <= 1'b1;
      if (overflow_now)
        control_ff[ssps_pkg::CT_OV] <= 1'b1;
    end
  end

  // status: sample and phase writable, i2c flags from event register
  always_ff @(posedge clock)
  begin
    if (srst)
      status_ff <= ssps_pkg::RST_STATUS;
    else
    begin
      if (wr_status)
        status_ff[7:6] <= avs_writedata[7:6];
      if (~port_enable)
      begin
        status_ff[ssps_pkg::ST_P] <= 1'b0;
        status_ff[ssps_pkg::ST_S] <= 1'b0;
      end
      else if (wr_events & is_i2c)
      begin
        status_ff[ssps_pkg::ST_DA] <= avs_writedata[ssps_pkg::EV_DATA];
        status_ff[ssps_pkg::ST_RW] <= avs_writedata[ssps_pkg::EV_RDDIR];
        status_ff[ssps_pkg::ST_REFRESH] <= avs_writedata[ssps_pkg::EV_ADDRQ]
          & (mode == ssps_pkg::SSPS_I2C10 | mode == ssps_pkg::SSPS_I2C10_SP);
        if (avs_writedata[ssps_pkg::EV_START])
        begin
          status_ff[ssps_pkg::ST_S] <= 1'b1;
          status_ff[ssps_pkg::ST_P] <= 1'b0;
          status_ff[ssps_pkg::ST_RW] <= 1'b0;
        end
        else if (avs_writedata[ssps_pkg::EV_STOP])
        begin
          status_ff[ssps_pkg::ST_P] <= 1'b1;
          status_ff[ssps_pkg::ST_S] <= 1'b0;
          status_ff[ssps_pkg::ST_RW] <= 1'b0;
        end
      end
    end
  end

  // port interrupt flag, write one to clear, set wins
  always_ff @(posedge clock)
  begin
    if (srst)
      irq_ff <= 1'b0;
    else if (word_done)
      irq_ff <= 1'b1;
    else if (wr_events & avs_writedata[ssps_pkg::EV_IRQ])
      irq_ff <= 1'b0;
  end
  assign port_irq = irq_ff;

  // pin ownership: enable hands pins to port
  always_comb
  begin
    pins.sck_o  = is_master ? sck_ff : 1'b0;
    pins.sck_oe = port_enable & (is_master | (is_i2c & ~clock_idle_level));
    pins.sdo_o  = (is_slave & ~busy_ff & shift_trail) ? tx_hold_ff[7] : sdo_ff;
    pins.sdo_oe = port_enable & (is_master | (is_slave & ~xfer_reset));
  end

endmodule

// ==== verilog/ssps_pkg.sv ====
// package: register map, field positions and mode codes for the serial port
package ssps_pkg;
  // register byte addresses on the avalon bus
  localparam logic [3:0] ADDR_STATUS  = 4'h0;  // serial_port_status
  localparam logic [3:0] ADDR_CONTROL = 4'h4;  // serial_port_control
  localparam logic [3:0] ADDR_BUFFER  = 4'h8;  // transfer_buffer
  localparam logic [3:0] ADDR_EVENTS  = 4'hc;  // i2c event inputs and port interrupt flag

  // status bit positions
  localparam int ST_SAMPLE = 7;
  localparam int ST_CKE = 6;
  localparam int ST_DA  = 5;
  localparam int ST_P   = 4;
  localparam int ST_S   = 3;
  localparam int ST_RW  = 2;
  localparam int ST_REFRESH = 1;
  localparam int ST_FULL    = 0;
  // control bit positions
  localparam int CT_COLL = 7;
  localparam int CT_OV   = 6;
  localparam int CT_EN   = 5;
  localparam int CT_IDLE = 4;
  // events register bit positions
  localparam int EV_IRQ   = 0;  // port interrupt flag, write one to clear
  localparam int EV_START = 1;  // write one: start condition seen
  localparam int EV_STOP  = 2;  // write one: stop condition seen
  localparam int EV_DATA  = 3;  // written value of the data/address flag
  localparam int EV_RDDIR = 4;  // written value of the read/write flag
  localparam int EV_ADDRQ = 5;  // written value of the address refresh flag

  // reset values
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;

  // master clock half periods in system clocks
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam int         BITS       = 8;

  // mode field encodings
  typedef enum logic [3:0] {
    SSPS_M_DIV4   = 4'h0,
    SSPS_M_DIV16  = 4'h1,
    SSPS_M_DIV64  = 4'h2,
    SSPS_M_TMR    = 4'h3,
    SSPS_S_CS     = 4'h4,
    SSPS_S_NOCS   = 4'h5,
    SSPS_I2C7     = 4'h6,
    SSPS_I2C10    = 4'h7,
    SSPS_I2C7_SP  = 4'hb,
    SSPS_I2C10_SP = 4'hf
  } ssps_mode_t;

  // serial pins toward the outside
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
  } ssps_pins_out_t;
endpackage

// ==== sim/ssps_asserts.sv ====
// checker: bus, pin and word timing properties of the serial port
`timescale 1ns/100ps
module ssps_asserts
(
  input wire logic                     clock,
  input wire logic                     srst,
  input wire logic [3:0]               avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [31:0]              avs_writedata,
  input wire logic [3:0]               avs_byteenable,
  input wire logic [31:0]              avs_readdata,
  input wire logic                     avs_waitrequest,
  input wire logic                     timer_two_output,
  input wire logic                     sck_i,
  input wire logic                     serial_in,
  input wire logic                     cs_n,
  input wire ssps_pkg::ssps_pins_out_t pins,
  input wire logic                     port_irq
);
  logic       en_ff;    // mirrored enable bit
  logic       idle_ff;  // mirrored idle level
  logic [3:0] mode_ff;  // mirrored mode field
  logic       sck_q_ff; // clock pin one cycle back
  logic [4:0] edge_ff;  // clock edges since last word
  // write taken at the first edge of the request, in step with the register
  wire cw = avs_write && avs_waitrequest && avs_address == ssps_pkg::ADDR_CONTROL && avs_byteenable[0];
  wire mst = en_ff && (mode_ff < 4'h4); // master modes only
  // mirror of control fields at the write edge
  always_ff @(posedge clock)
    if (srst)
      {en_ff, idle_ff, mode_ff} <= 6'h00;
    else if (cw)
      {en_ff, idle_ff, mode_ff} <= avs_writedata[5:0];
  // edge counter, cleared at each word end
  always_ff @(posedge clock)
  begin
    sck_q_ff <= pins.sck_o;
    if (srst || !mst || $rose(port_irq))
      edge_ff <= 5'h00;
    else if (pins.sck_o != sck_q_ff)
      edge_ff <= edge_ff + 5'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // a request that rises after an idle cycle
  sequence req_start;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence word_end;
    mst && $rose(port_irq);
  endsequence
  AST_WAIT_ONE: assert property (req_start |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  AST_RD_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_RST_QUIET: assert property (disable iff (1'b0) srst |=> !port_irq && !pins.sck_oe && !pins.sdo_oe)
    else $error("outputs active after reset");
  AST_OFF_PINS: assert property (!en_ff && !$past(en_ff) |-> !pins.sck_oe && !pins.sdo_oe)
    else $error("pins driven while disabled");
  AST_SCK_DIR: assert property (en_ff && $past(en_ff) |-> pins.sck_oe == (mode_ff < 4'h4))
    else $error("clock direction wrong for mode");
  AST_IDLE_LVL: assert property (word_end |-> pins.sck_o == idle_ff)
    else $error("clock not idle at word end");
  AST_EDGES: assert property (word_end |-> (edge_ff + {4'h0, pins.sck_o != sck_q_ff}) == 5'd16)
    else $error("word not sixteen clock edges");
  AST_NO_OV: assert property (avs_read && !avs_waitrequest && avs_address == ssps_pkg::ADDR_CONTROL && mst
    |-> !avs_readdata[6])
    else $error("overflow flagged in master mode");
endmodule

bind ssps_top ssps_asserts chk_i (.clock(clock), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timer_two_output(timer_two_output), .sck_i(sck_i), .serial_in(serial_in), .cs_n(cs_n),
  .pins(pins), .port_irq(port_irq));

// ==== sim/ssps_peer.sv ====
// far-side spi peripheral model: idle-low clock, phase zero
`timescale 1ns/100ps
module ssps_peer
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh_ff; // outgoing bits, spent ones inverted
  // capture on rising clock, msb first
  always @(posedge sck)
    rx_byte <= {rx_byte[6:0], mosi};
  // next bit after falling clock
  always @(negedge sck or posedge load)
    if (load)
      sh_ff <= tx_byte;
    else
      sh_ff <= {sh_ff[6:0], ~sh_ff[7]};
  assign miso = sh_ff[7];
endmodule

// ==== sim/testbench.sv ====
// self-checking bench: registers, master words, slave words
`timescale 1ns/100ps
module testbench;
  logic clock, srst, avs_read, avs_write, sck_i, serial_in, cs_n, tmr, load, slv;
  logic [3:0]               avs_address;   // bus address
  logic [31:0]              avs_writedata; // bus write data
  logic [31:0]              avs_readdata;  // bus read data
  logic                     avs_waitrequest, port_irq, miso;
  logic [7:0]               q, ptx, prx, got;
  ssps_pkg::ssps_pins_out_t pins;          // pin drive
  int                       fail_count, total_checks;
  wire sin = slv ? serial_in : miso; // data source per role
  ssps_top dut (.clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_two_output(tmr),
    .sck_i(sck_i), .serial_in(sin), .cs_n(cs_n), .pins(pins), .port_irq(port_irq));
  ssps_peer peer (.sck(pins.sck_o), .mosi(pins.sdo_o), .load(load), .tx_byte(ptx), .miso(miso),
    .rx_byte(prx));
  // system clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // timer output, rising every ten clocks
  always
  begin
    repeat (5) @(posedge clock);
    tmr <= ~tmr;
  end
  // verdict and end of run
  task automatic results;
    if (fail_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0)
        break;
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk(8'(n == 50), 8'h00);
    if (n == 50)
      results;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  // bounded wait for word complete
  task automatic wait_irq;
    int n;
    for (n = 0; n < 3000; n++)
    begin
      @(posedge clock);
      if (port_irq === 1'b1)
        break;
    end
    chk(8'(n == 3000), 8'h00);
    if (n == 3000)
      results;
  endtask
  // master word with peer exchange
  task automatic mxfer(input logic [3:0] m, input logic [7:0] tx, input logic [7:0] pt);
    wr(ssps_pkg::ADDR_CONTROL, 8'h00); // disable before reconfiguring
    ptx <= pt;
    load <= 1'b1;
    wr(ssps_pkg::ADDR_CONTROL, {4'h2, m});
    load <= 1'b0;
    wr(ssps_pkg::ADDR_BUFFER, tx);
    wait_irq;
    rd(ssps_pkg::ADDR_BUFFER, pt);
    chk(prx, tx);
    wr(ssps_pkg::ADDR_EVENTS, 8'h01);
  endtask
  // slave bits as far-side master, half period eight clocks
  task automatic sbits(input logic [7:0] b, input int k);
    for (int i = 7; i > 7 - k; i--)
    begin
      serial_in <= b[i];
      repeat (8) @(negedge clock);
      got[i] = pins.sdo_o;
      @(posedge clock);
      sck_i <= 1'b1;
      repeat (8) @(posedge clock);
      sck_i <= 1'b0;
    end
    serial_in <= ~serial_in;
  endtask
  // main sequence
  initial
  begin
    {srst, avs_read, avs_write, sck_i, serial_in, cs_n, tmr, load, slv} = 9'h108;
    {avs_address, avs_writedata, ptx, fail_count, total_checks} = '0;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rd(ssps_pkg::ADDR_STATUS, ssps_pkg::RST_STATUS);
    rd(ssps_pkg::ADDR_CONTROL, ssps_pkg::RST_CONTROL);
    rd(4'h2, 8'h00);
    chk({6'h0, pins.sck_oe, pins.sdo_oe}, 8'h00);
    for (int i = 1; i < 4; i++)
      mxfer(4'(i), 8'ha5 ^ 8'(i), 8'h3c + 8'(i));
    chk({6'h0, pins.sck_oe, pins.sdo_oe}, 8'h03);
    wr(ssps_pkg::ADDR_STATUS, 8'h80);
    mxfer(4'h1, 8'h5e, 8'hc9);
    mxfer(4'h0, 8'ha5, 8'h3c);
    wr(ssps_pkg::ADDR_STATUS, 8'h00); // sample bit clear before slave use
    mxfer(4'h3, 8'h11, 8'h22);
    wr(ssps_pkg::ADDR_BUFFER, 8'h81);
    wr(ssps_pkg::ADDR_BUFFER, 8'h7e);
    wait_irq;
    chk(prx, 8'h81);
    rd(ssps_pkg::ADDR_STATUS, 8'h01);
    wr(ssps_pkg::ADDR_EVENTS, 8'h01);
    wr(ssps_pkg::ADDR_BUFFER, 8'h42);
    wait_irq;
    rd(ssps_pkg::ADDR_CONTROL, 8'ha3);
    bus(1'b0, ssps_pkg::ADDR_BUFFER, 8'h00);
    rd(ssps_pkg::ADDR_STATUS, 8'h00);
    wr(ssps_pkg::ADDR_CONTROL, 8'h23);
    rd(ssps_pkg::ADDR_CONTROL, 8'h23);
    wr(ssps_pkg::ADDR_EVENTS, 8'h01);
    wr(ssps_pkg::ADDR_CONTROL, 8'h00);
    wr(ssps_pkg::ADDR_CONTROL, 8'h30);
    repeat (4) @(posedge clock);
    chk({7'h0, pins.sck_o}, 8'h01);
    wr(ssps_pkg::ADDR_CONTROL, 8'h00);
    repeat (4) @(posedge clock);
    chk({6'h0, pins.sck_oe, pins.sdo_oe}, 8'h00);
    slv <= 1'b1;
    wr(ssps_pkg::ADDR_CONTROL, 8'h25); // slave mode 5 ignores chip select; phase zero
    wr(ssps_pkg::ADDR_BUFFER, 8'h96);
    sbits(8'hc3, 8);
    chk(got, 8'h96);
    wait_irq;
    sbits(8'h5a, 8);
    repeat (8) @(posedge clock);
    rd(ssps_pkg::ADDR_CONTROL, 8'h65);
    rd(ssps_pkg::ADDR_BUFFER, 8'hc3);
    wr(ssps_pkg::ADDR_EVENTS, 8'h01);
    wr(ssps_pkg::ADDR_CONTROL, 8'h00);
    wr(ssps_pkg::ADDR_CONTROL, 8'h24);
    cs_n <= 1'b0;
    sbits(8'hff, 4);
    cs_n <= 1'b1;
    repeat (8) @(posedge clock);
    cs_n <= 1'b0;
    sbits(8'h3c, 8);
    wait_irq;
    rd(ssps_pkg::ADDR_BUFFER, 8'h3c);
    results;
  end
endmodule
